//--- shared/misc_op_pkg.sv
// constants, operation codes and carriers for the misc instruction unit
// assumes a single core clock and a sequencer that issues one op at a time
// Overview of operation
// - program_memory_load copies byte at Z into destination, then Z+1; 3 cycles
// - push writes src_reg onto the stack; no flags; 2 cycles
// - pop loads destination from top of stack; no flags; 2 cycles
// - sleep takes one cycle, no flags, starts the configured sleep mode
// - watchdog_restart_op takes one cycle, no flags, restarts watchdog count
// - break is acted on by the debug logic only; no flags
package misc_op_pkg;

    localparam int unsigned DATA_W      = 8;
    localparam int unsigned ADDR_W      = 16;
    localparam int unsigned REG_IDX_W   = 5;
    localparam int unsigned CYC_PMEM_LD = 3;
    localparam int unsigned CYC_PUSH    = 2;
    localparam int unsigned CYC_POP     = 2;
    localparam int unsigned CYC_CTRL    = 1;
    localparam int unsigned CNT_W       = 2;
    localparam logic [ADDR_W-1:0] SP_RESET = 16'h04ff;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_PMEM_LOAD,
        OP_PUSH,
        OP_POP,
        OP_SLEEP,
        OP_WDOG_RESTART,
        OP_BREAK
    } misc_op_e;

    typedef struct packed {
        misc_op_e              op;
        logic [REG_IDX_W-1:0]  reg_idx;
        logic [DATA_W-1:0]     src_reg;
    } misc_cmd_s;

    typedef struct packed {
        logic                  we;
        logic [REG_IDX_W-1:0]  idx;
        logic [DATA_W-1:0]     data;
    } reg_wr_s;

endpackage

//--- hdl/misc_op_unit.sv
// executor for program memory load, push, pop, sleep, watchdog restart, break
// assumes program memory data arrives the cycle after its read strobe
// and stack memory data stands within the strobe cycle, both on clk_in
`timescale 1ns/1ps
`default_nettype none
module misc_op_unit
    import misc_op_pkg::*;
(
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    // command from the sequencer
    input  wire logic              cmd_valid_in,
    input  var  misc_cmd_s         cmd_in,
    output logic                   cmd_ready_out,
    output logic                   done_out,
    // z pointer
    input  wire logic [ADDR_W-1:0] z_ptr_in,
    output logic                   z_we_out,
    output logic [ADDR_W-1:0]      z_ptr_out,
    // program memory
    output logic                   pmem_rd_out,
    output logic [ADDR_W-1:0]      pmem_addr_out,
    input  wire logic [DATA_W-1:0] pmem_data_in,
    // data memory for the stack
    output logic                   dmem_rd_out,
    output logic                   dmem_wr_out,
    output logic [ADDR_W-1:0]      dmem_addr_out,
    output logic [DATA_W-1:0]      dmem_wdata_out,
    input  wire logic [DATA_W-1:0] dmem_rdata_in,
    // register file write port
    output reg_wr_s                reg_wr_out,
    // stack pointer view
    output logic [ADDR_W-1:0]      sp_out,
    // control side effects
    output logic                   sleep_req_out,
    output logic                   wdog_restart_out,
    input  wire logic              debug_enable_in,
    output logic                   debug_break_out
);

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_LAST} exec_e;

    exec_e                exec_reg;
    misc_op_e             op_reg;
    logic [REG_IDX_W-1:0] idx_reg;
    logic [CNT_W-1:0]     cnt_reg;
    logic [ADDR_W-1:0]    sp_reg;
    logic                 take;

    function automatic logic [CNT_W-1:0] cycles_of(input misc_op_e op);
        case (op)
            OP_PMEM_LOAD: cycles_of = CNT_W'(CYC_PMEM_LD);
            OP_PUSH:      cycles_of = CNT_W'(CYC_PUSH);
            OP_POP:       cycles_of = CNT_W'(CYC_POP);
            default:      cycles_of = CNT_W'(CYC_CTRL);
        endcase
    endfunction

    assign take          = cmd_valid_in && exec_reg == ST_IDLE;
    assign cmd_ready_out = exec_reg == ST_IDLE;
    assign sp_out        = sp_reg;

    // sequencing: multi-cycle ops count down their cycles
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            exec_reg <= ST_IDLE;
            op_reg   <= OP_NONE;
            idx_reg  <= '0;
            cnt_reg  <= '0;
        end else begin
            case (exec_reg)
                ST_IDLE: begin
                    if (take && cycles_of(cmd_in.op) > CNT_W'(1)) begin
                        op_reg   <= cmd_in.op;
                        idx_reg  <= cmd_in.reg_idx;
                        cnt_reg  <= cycles_of(cmd_in.op) - CNT_W'(1);
                        exec_reg <= (cycles_of(cmd_in.op) == CNT_W'(2))
                                    ? ST_LAST : ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    cnt_reg  <= cnt_reg - CNT_W'(1);
                    exec_reg <= (cnt_reg == CNT_W'(2)) ? ST_LAST : ST_WAIT;
                end
                default: begin
                    exec_reg <= ST_IDLE;
                    op_reg   <= OP_NONE;
                end
            endcase
        end
    end

    // memory strobes; cycle after issue for push/pop/load, no flags touched
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pmem_rd_out    <= 1'b0;
            pmem_addr_out  <= '0;
            dmem_rd_out    <= 1'b0;
            dmem_wr_out    <= 1'b0;
            dmem_addr_out  <= '0;
            dmem_wdata_out <= '0;
        end else begin
            pmem_rd_out <= take && cmd_in.op == OP_PMEM_LOAD;
            dmem_wr_out <= take && cmd_in.op == OP_PUSH;
            dmem_rd_out <= take && cmd_in.op == OP_POP;
            if (take && cmd_in.op == OP_PMEM_LOAD) begin
                pmem_addr_out <= z_ptr_in;
            end
            if (take && cmd_in.op == OP_PUSH) begin
                dmem_addr_out  <= sp_reg;
                dmem_wdata_out <= cmd_in.src_reg;
            end else if (take && cmd_in.op == OP_POP) begin
                dmem_addr_out <= sp_reg + ADDR_W'(1);
            end
        end
    end

    // stack pointer: post-decrement on push, pre-increment on pop
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sp_reg <= SP_RESET;
        end else if (take && cmd_in.op == OP_PUSH) begin
            sp_reg <= sp_reg - ADDR_W'(1);
        end else if (take && cmd_in.op == OP_POP) begin
            sp_reg <= sp_reg + ADDR_W'(1);
        end
    end

    // z post-increment after the load address is taken
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            z_we_out  <= 1'b0;
            z_ptr_out <= '0;
        end else begin
            z_we_out <= take && cmd_in.op == OP_PMEM_LOAD;
            if (take && cmd_in.op == OP_PMEM_LOAD) begin
                z_ptr_out <= z_ptr_in + ADDR_W'(1);
            end
        end
    end

    // register write-back in the final cycle
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_wr_out <= '0;
        end else begin
            reg_wr_out.we <= 1'b0;
            if (exec_reg == ST_LAST && op_reg == OP_PMEM_LOAD) begin
                reg_wr_out.we   <= 1'b1;
                reg_wr_out.idx  <= idx_reg;
                reg_wr_out.data <= pmem_data_in;
            end else if (exec_reg == ST_LAST && op_reg == OP_POP) begin
                reg_wr_out.we   <= 1'b1;
                reg_wr_out.idx  <= idx_reg;
                reg_wr_out.data <= dmem_rdata_in;
            end
        end
    end

    // single-cycle control ops
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sleep_req_out    <= 1'b0;
            wdog_restart_out <= 1'b0;
            debug_break_out  <= 1'b0;
        end else begin
            sleep_req_out    <= take && cmd_in.op == OP_SLEEP;
            wdog_restart_out <= take && cmd_in.op == OP_WDOG_RESTART;
            debug_break_out  <= take && cmd_in.op == OP_BREAK
                                && debug_enable_in;
        end
    end

    // completion: single-cycle ops at issue, others in final cycle
    assign done_out = (take && cycles_of(cmd_in.op) == CNT_W'(1))
                      || exec_reg == ST_LAST;

endmodule // misc_op_unit
`default_nettype wire

//--- testbench/misc_op_sva.sv
// assertions on the misc_op_unit ports
// assumes one clock and the async high reset of the unit
`timescale 1ns/1ps
`default_nettype none
module misc_op_sva
    import misc_op_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic        cmd_valid_in,
    input var  misc_cmd_s   cmd_in,
    input wire logic        cmd_ready_out,
    input wire logic        done_out,
    input wire logic        z_we_out,
    input wire logic [15:0] z_ptr_out,
    input wire logic        pmem_rd_out,
    input wire logic [15:0] pmem_addr_out,
    input wire logic        dmem_rd_out,
    input wire logic        dmem_wr_out,
    input wire logic [15:0] dmem_addr_out,
    input wire logic [15:0] sp_out,
    input wire logic        sleep_req_out,
    input wire logic        wdog_restart_out,
    input wire logic        debug_enable_in,
    input wire logic        debug_break_out
);
default clocking @(posedge clk_in); endclocking
default disable iff (rst_in);
wire tk = cmd_valid_in & cmd_ready_out;
ld_timing_a: assert property (tk && cmd_in.op == OP_PMEM_LOAD |->
    !done_out ##1 pmem_rd_out && z_we_out && !done_out ##1 done_out)
    else $error("load timing wrong");
z_inc_a: assert property (z_we_out |-> z_ptr_out == pmem_addr_out + 16'h1)
    else $error("z not incremented");
push_sp_a: assert property (tk && cmd_in.op == OP_PUSH |-> ##1 dmem_wr_out
    && done_out && dmem_addr_out == $past(sp_out)
    && sp_out == $past(sp_out) - 16'h1) else $error("push wrong");
pop_sp_a: assert property (tk && cmd_in.op == OP_POP |-> ##1 dmem_rd_out
    && done_out && sp_out == $past(sp_out) + 16'h1
    && dmem_addr_out == sp_out) else $error("pop wrong");
sleep_req_a: assert property (tk && cmd_in.op == OP_SLEEP |->
    done_out ##1 sleep_req_out) else $error("sleep request missing");
wdog_pulse_a: assert property (tk && cmd_in.op == OP_WDOG_RESTART |->
    done_out ##1 wdog_restart_out) else $error("restart missing");
brk_cause_a: assert property (debug_break_out |-> $past(debug_enable_in)
    && $past(cmd_in.op) == OP_BREAK) else $error("stray break");
cover property (tk && cmd_in.op == OP_POP);
cover property (tk && cmd_in.op == OP_PMEM_LOAD);
cover property (debug_break_out);
endmodule // misc_op_sva
bind misc_op_unit misc_op_sva u_sva (
    .clk_in           (clk_in),
    .rst_in           (rst_in),
    .cmd_valid_in     (cmd_valid_in),
    .cmd_in           (cmd_in),
    .cmd_ready_out    (cmd_ready_out),
    .done_out         (done_out),
    .z_we_out         (z_we_out),
    .z_ptr_out        (z_ptr_out),
    .pmem_rd_out      (pmem_rd_out),
    .pmem_addr_out    (pmem_addr_out),
    .dmem_rd_out      (dmem_rd_out),
    .dmem_wr_out      (dmem_wr_out),
    .dmem_addr_out    (dmem_addr_out),
    .sp_out           (sp_out),
    .sleep_req_out    (sleep_req_out),
    .wdog_restart_out (wdog_restart_out),
    .debug_enable_in  (debug_enable_in),
    .debug_break_out  (debug_break_out)
);
`default_nettype wire

//--- testbench/misc_op_unit_tb.sv
// self-checking bench for misc_op_unit
// bench models program memory, stack memory and z register
`timescale 1ns/1ps
`default_nettype none
module misc_op_unit_tb
    import misc_op_pkg::*;
;
logic clk_in = 0, rst_in = 1, cmd_valid_in = 0, debug_enable_in = 0;
misc_cmd_s cmd_in = '0;
logic [15:0] z_ptr_in = 16'h0100, z_ptr_out, pmem_addr_out, dmem_addr_out;
logic [15:0] sp_out;
logic [7:0] pmem_data_in = '0, dmem_rdata_in = '0, dmem_wdata_out;
logic cmd_ready_out, done_out, z_we_out, pmem_rd_out, dmem_rd_out;
logic dmem_wr_out, sleep_req_out, wdog_restart_out, debug_break_out;
reg_wr_s reg_wr_out;
int failures = 0, n_compared = 0, nsl = 0, nwd = 0, nbk = 0;
logic pr = 1'b0;
logic [12:0] q[$];
logic [7:0] stk[$];
logic [7:0] mem[logic [15:0]];
misc_op_unit dut (
    .clk_in           (clk_in),
    .rst_in           (rst_in),
    .cmd_valid_in     (cmd_valid_in),
    .cmd_in           (cmd_in),
    .cmd_ready_out    (cmd_ready_out),
    .done_out         (done_out),
    .z_ptr_in         (z_ptr_in),
    .z_we_out         (z_we_out),
    .z_ptr_out        (z_ptr_out),
    .pmem_rd_out      (pmem_rd_out),
    .pmem_addr_out    (pmem_addr_out),
    .pmem_data_in     (pmem_data_in),
    .dmem_rd_out      (dmem_rd_out),
    .dmem_wr_out      (dmem_wr_out),
    .dmem_addr_out    (dmem_addr_out),
    .dmem_wdata_out   (dmem_wdata_out),
    .dmem_rdata_in    (dmem_rdata_in),
    .reg_wr_out       (reg_wr_out),
    .sp_out           (sp_out),
    .sleep_req_out    (sleep_req_out),
    .wdog_restart_out (wdog_restart_out),
    .debug_enable_in  (debug_enable_in),
    .debug_break_out  (debug_break_out)
);
always #2 clk_in = ~clk_in;
task chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
        failures++;
        $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
endtask
task wrap_up;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
endtask
task automatic op(input misc_op_e o, input logic [7:0] d);
    cmd_in = '{o, d[4:0], d};
    cmd_valid_in = 1;
    while (!cmd_ready_out) @(negedge clk_in);
    if (o == OP_PUSH) stk.push_back(d);
    if (o == OP_POP) q.push_back({d[4:0], stk.pop_back()});
    if (o == OP_PMEM_LOAD) q.push_back({d[4:0], z_ptr_in[7:0] ^ 8'ha5});
    @(negedge clk_in);
endtask
// program data stands through the cycle after its strobe;
// stack data answers within the strobe cycle
always @(negedge clk_in) begin
    pmem_data_in <= pmem_rd_out ? pmem_addr_out[7:0] ^ 8'ha5
                    : (pr ? pmem_data_in : ~pmem_data_in);
    pr <= pmem_rd_out;
    if (dmem_wr_out) mem[dmem_addr_out] = dmem_wdata_out;
    dmem_rdata_in <= dmem_rd_out ? mem[dmem_addr_out] : ~dmem_rdata_in;
    if (z_we_out) begin
        chk(z_ptr_out, z_ptr_in + 16'h1);
        z_ptr_in <= z_ptr_in + 16'h1;
    end
    if (reg_wr_out.we) chk({3'h0, reg_wr_out.idx, reg_wr_out.data}, {3'h0, q.pop_front()});
    nsl += sleep_req_out;
    nwd += wdog_restart_out;
    nbk += debug_break_out;
end
initial begin
    #4000;
    failures++;
    wrap_up;
end
initial begin
    void'($urandom(32'h5ec7));
    repeat (12) @(negedge clk_in);
    rst_in = 0;
    chk(sp_out, SP_RESET);
    for (int i = 0; i < 6; i++) op(OP_PUSH, 8'($urandom));
    op(OP_NONE, 8'h0);
    chk(sp_out, SP_RESET - 16'h6);
    for (int i = 0; i < 6; i++) op(OP_POP, 8'($urandom));
    op(OP_NONE, 8'h0);
    chk(sp_out, SP_RESET);
    for (int i = 0; i < 4; i++) op(OP_PMEM_LOAD, 8'($urandom));
    op(OP_SLEEP, 8'h0);
    op(OP_WDOG_RESTART, 8'h0);
    op(OP_BREAK, 8'h0);
    debug_enable_in = 1;
    op(OP_BREAK, 8'h0);
    cmd_valid_in = 0;
    repeat (4) @(negedge clk_in);
    chk(16'(nsl), 16'h1);
    chk(16'(nwd), 16'h1);
    chk(16'(nbk), 16'h1);
    chk(16'(q.size()), 16'h0);
    wrap_up;
end
endmodule // misc_op_unit_tb
`default_nettype wire
